// File: rtl/tecpfd_pkg.sv
// Purpose: Shared constants and carriers for the timer/event counter
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Offsets are byte addresses of word registers
package tecpfd_pkg;
   localparam int ADDR_W = 8;
   // Printed offsets are not word aligned: kept as indexes
   localparam logic [ADDR_W-1:0] IDX_COUNT = 8'h0d;
   localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h0e;
   localparam logic [ADDR_W-1:0] IDX_INTERRUPT_CONTROL = 8'h0f;
   localparam logic [ADDR_W-1:0] IDX_PORT = 8'h10;
   localparam logic [ADDR_W+1:0] ADDR_COUNT = {IDX_COUNT, 2'b00};
   localparam logic [ADDR_W+1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [ADDR_W+1:0] ADDR_INTERRUPT_CONTROL = {IDX_INTERRUPT_CONTROL, 2'b00};
   localparam logic [ADDR_W+1:0] ADDR_PORT = {IDX_PORT, 2'b00};
   // Control fields
   localparam int CTRL_MODE_HI = 7;
   localparam int CTRL_MODE_LO = 6;
   localparam int CTRL_RUN = 4;
   localparam int CTRL_EDGE = 3;
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [7:0] CTRL_WMASK = 8'hdf;
   // Interrupt control fields
   localparam int INTERRUPT_CONTROL_ENABLE = 0;
   localparam int INTERRUPT_CONTROL_FLAG = 5;
   // Port control fields
   localparam int PORT_LATCH = 0;
   localparam int PORT_DIR_IN = 1;
   localparam int PORT_PFD_SEL = 2;
   localparam logic [2:0] PORT_RESET = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int CNT_W = 8;
   localparam int PSC_W = 7;
   typedef enum logic [1:0] {
      TECPFD_MODE_OFF = 2'h0,
      TECPFD_MODE_EVENT = 2'h1,
      TECPFD_MODE_TIMER = 2'h2,
      TECPFD_MODE_PULSE = 2'h3
   } tecpfd_mode_e;
   typedef struct packed {
      logic [ADDR_W+1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } tecpfd_wreq_s;
   typedef struct packed {
      logic [31:0] data;
      logic [1:0] resp;
   } tecpfd_rrsp_s;
endpackage

// File: rtl/tecpfd_top.sv
// Purpose: 8-bit timer/event counter with prescaler and divider output
// Assumes: Counter input may be asynchronous to mclk; synchronised here
// Notes: AXI4-Lite slave, one access of each kind at a time
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [RQ1] Eight-bit up-counter clocked by input pin or prescaled system clock.
// [RQ2] Count location write goes to reload register; read returns live count.
// [RQ3] Mode bits 7:6 select event, timer, pulse-width or unused.
// [RQ4] Event/timer count to ff, overflow reloads and sets flag same cycle.
// [RQ5] Pulse mode counts from start edge until level returns, then clears run.
// [RQ6] Measured count held after completion until software sets run again.
// [RQ7] Pulse measurement starts on an input edge, not a level.
// [RQ8] Pulse-mode overflow reloads and raises the flag like other modes.
// [RQ9] Count only while run is set; event/timer never clear run.
// [RQ10] Overflow is offered as a wake-up event.
// [RQ11] Interrupt enable at zero blocks interrupt service in all modes.
// [RQ12] Reload write while stopped also loads counter; running only reload.
// [RQ13] Count clock blocked during a counter read.
// [RQ14] Prescale field divides system clock by two to its value.
// [RQ15] Event mode edge select: one falling, zero rising.
// [RQ16] Pulse mode edge select: one high pulse, zero low pulse.
// [RQ17] Control bit 5 reads zero.
// [RQ18] Divider output toggles on each overflow.
// [RQ19] Pin shows divider gated by latch in output mode, else port value.
// [RQ20] Mode 00 never counts, overflows or toggles.
// [RQ21] Counter input synchronised and edge-detected from successive samples.
module tecpfd_top
   import tecpfd_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [tecpfd_pkg::ADDR_W+1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [tecpfd_pkg::ADDR_W+1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic count_in,
   output logic timer_irq,
   output logic wake_up,
   output logic div_pin_o,
   output logic div_pin_oe_n
);
   import tecpfd_pkg::*;

   if (CNT_W != 8 || PSC_W != 7) begin : g_bad_width
      $error("Unsupported counter or prescaler width");
   end

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic logic edge_hit(input logic cur, input logic prev, input logic rise);
      edge_hit = rise ? (cur & ~prev) : (~cur & prev);
   endfunction

   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   tecpfd_wreq_s wreq_q;
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] ctrl_q;
   logic [7:0] reload_q;
   logic [7:0] count_q;
   logic flag_q;
   logic irq_en_q;
   logic [2:0] port_q;
   logic run_clr;
   logic ovf;
   logic rd_block;
   logic wr_fire;
   logic wr_count;
   logic wr_ctrl;
   logic wr_interrupt_control;
   logic wr_port;
   tecpfd_rrsp_s rrsp;

   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_count = wr_fire && wreq_q.addr == ADDR_COUNT && wreq_q.strb[0];
   assign wr_ctrl = wr_fire && wreq_q.addr == ADDR_CTRL && wreq_q.strb[0];
   assign wr_interrupt_control = wr_fire && wreq_q.addr == ADDR_INTERRUPT_CONTROL && wreq_q.strb[0];
   assign wr_port = wr_fire && wreq_q.addr == ADDR_PORT && wreq_q.strb[0];
   // Read address handshake blocks counting for that cycle
   assign rd_block = s_axi_arvalid && s_axi_arready; // RQ13

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         wreq_q <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
            wreq_q.addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
            wreq_q.data <= s_axi_wdata;
            wreq_q.strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wreq_q.addr == ADDR_COUNT || wreq_q.addr == ADDR_CTRL ||
                            wreq_q.addr == ADDR_INTERRUPT_CONTROL || wreq_q.addr == ADDR_PORT) ?
                           RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_comb begin
      rrsp.resp = RESP_OKAY;
      rrsp.data = '0;
      case (s_axi_araddr)
         ADDR_COUNT: rrsp.data[7:0] = count_q; // RQ2
         ADDR_CTRL: rrsp.data[7:0] = ctrl_q & CTRL_WMASK; // RQ17
         ADDR_INTERRUPT_CONTROL: begin
            rrsp.data[INTERRUPT_CONTROL_FLAG] = flag_q;
            rrsp.data[INTERRUPT_CONTROL_ENABLE] = irq_en_q;
         end
         ADDR_PORT: rrsp.data[2:0] = port_q;
         default: rrsp.resp = RESP_SLVERR;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         if (rd_block) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rrsp.data;
            s_axi_rresp <= rrsp.resp;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Control, reload and port registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= wreq_q.data[7:0] & CTRL_WMASK; // RQ17
      end else if (run_clr) begin
         ctrl_q[CTRL_RUN] <= 1'b0; // RQ5
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         reload_q <= '0;
      end else if (wr_count) begin
         reload_q <= wreq_q.data[7:0]; // RQ2
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         port_q <= PORT_RESET;
         irq_en_q <= 1'b0;
      end else begin
         if (wr_port) begin
            port_q <= wreq_q.data[2:0];
         end
         if (wr_interrupt_control) begin
            irq_en_q <= wreq_q.data[INTERRUPT_CONTROL_ENABLE];
         end
      end
   end

   // Overflow sets, software write of zero clears; set wins
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= 1'b0;
      end else if (ovf) begin
         flag_q <= 1'b1; // RQ4
      end else if (wr_interrupt_control && !wreq_q.data[INTERRUPT_CONTROL_FLAG]) begin
         flag_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Input sampling and prescaler
   // ---------------------------------------------------------------
   tecpfd_mode_e mode;
   logic run;
   logic edge_sel;
   logic in_s1_q;
   logic in_s2_q;
   logic in_s3_q;
   logic ev_edge;
   logic pw_start;
   logic pw_stop;
   logic [PSC_W-1:0] psc_q;
   logic psc_tick;
   logic [PSC_W-1:0] psc_mask;
   logic pw_active_q;
   logic inc;

   assign mode = tecpfd_mode_e'(ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO]); // RQ3
   assign run = ctrl_q[CTRL_RUN];
   assign edge_sel = ctrl_q[CTRL_EDGE];

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         in_s1_q <= 1'b0;
         in_s2_q <= 1'b0;
         in_s3_q <= 1'b0;
      end else begin
         in_s1_q <= count_in; // RQ21
         in_s2_q <= in_s1_q;
         in_s3_q <= in_s2_q;
      end
   end

   assign ev_edge = edge_hit(in_s2_q, in_s3_q, !edge_sel); // RQ15
   assign pw_start = edge_hit(in_s2_q, in_s3_q, edge_sel); // RQ16
   assign pw_stop = edge_hit(in_s2_q, in_s3_q, !edge_sel); // RQ16

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         psc_q <= '0;
      end else begin
         psc_q <= psc_q + 7'h01; // RQ14
      end
   end
   assign psc_mask = PSC_W'((8'h01 << ctrl_q[2:0]) - 8'h01);
   assign psc_tick = (psc_q & psc_mask) == '0; // RQ14

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pw_active_q <= 1'b0;
      end else if (mode != TECPFD_MODE_PULSE || !run) begin
         pw_active_q <= 1'b0;
      end else if (!pw_active_q && pw_start) begin
         pw_active_q <= 1'b1; // RQ7
      end else if (pw_active_q && pw_stop) begin
         pw_active_q <= 1'b0; // RQ5
      end
   end
   assign run_clr = pw_active_q && pw_stop && mode == TECPFD_MODE_PULSE && run; // RQ5

   always_comb begin
      case (mode)
         TECPFD_MODE_EVENT: inc = ev_edge;
         TECPFD_MODE_TIMER: inc = psc_tick;
         TECPFD_MODE_PULSE: inc = pw_active_q && !pw_stop && psc_tick; // RQ6
         default: inc = 1'b0; // RQ20
      endcase
      inc = inc && run && !rd_block; // RQ9 RQ13
   end
   assign ovf = inc && count_q == 8'hff; // RQ4 RQ8

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= '0;
      end else if (wr_count && !run) begin
         count_q <= wreq_q.data[7:0]; // RQ12
      end else if (ovf) begin
         count_q <= reload_q; // RQ4
      end else if (inc) begin
         count_q <= count_q + 8'h01; // RQ1
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic pfd_q;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pfd_q <= 1'b0;
         timer_irq <= 1'b0;
         wake_up <= 1'b0;
         div_pin_o <= 1'b0;
         div_pin_oe_n <= 1'b1;
      end else begin
         if (ovf) begin
            pfd_q <= ~pfd_q; // RQ18
         end
         timer_irq <= (flag_q || ovf) && irq_en_q; // RQ11
         wake_up <= ovf; // RQ10
         div_pin_oe_n <= port_q[PORT_DIR_IN]; // RQ19
         div_pin_o <= port_q[PORT_PFD_SEL] ? (port_q[PORT_LATCH] & (ovf ? ~pfd_q : pfd_q))
                                           : port_q[PORT_LATCH]; // RQ19
      end
   end

   AST_FLAG_ON_OVF: assert property (@(posedge mclk) disable iff (!arst_n)
      ovf |=> flag_q) else $error("Flag missing after overflow"); // RQ4
   AST_RELOAD: assert property (@(posedge mclk) disable iff (!arst_n)
      ovf && !wr_count |=> count_q == $past(reload_q)) else $error("No reload"); // RQ4
   AST_STOPPED: assert property (@(posedge mclk) disable iff (!arst_n)
      !run && !wr_count |=> $stable(count_q)) else $error("Counted while stopped"); // RQ9
   AST_OFF_MODE: assert property (@(posedge mclk) disable iff (!arst_n)
      mode == TECPFD_MODE_OFF |-> !ovf) else $error("Overflow in mode off"); // RQ20
   AST_LOAD_STOPPED: assert property (@(posedge mclk) disable iff (!arst_n)
      wr_count && !run |=> count_q == $past(wreq_q.data[7:0])) else $error("No load"); // RQ12
   AST_READ_BLOCK: assert property (@(posedge mclk) disable iff (!arst_n)
      rd_block && !wr_count |=> $stable(count_q)) else $error("Counted during read"); // RQ13
   AST_PFD_TOGGLE: assert property (@(posedge mclk) disable iff (!arst_n)
      ovf |=> pfd_q != $past(pfd_q)) else $error("Divider did not toggle"); // RQ18
   // Run dropped, then count frozen unless reloaded by software
   sequence run_dropped_seq;
      !run ##1 ($stable(count_q) || wr_count);
   endsequence
   AST_RUN_CLR: assert property (@(posedge mclk) disable iff (!arst_n)
      run_clr && !wr_ctrl |=> run_dropped_seq)
      else $error("Pulse end not held"); // RQ5
   AST_BIT5: assert property (@(posedge mclk) disable iff (!arst_n)
      !ctrl_q[5]) else $error("Bit 5 set"); // RQ17
   AST_IRQ_MASK: assert property (@(posedge mclk) disable iff (!arst_n)
      !irq_en_q |=> !timer_irq) else $error("Masked irq raised"); // RQ11

endmodule // tecpfd_top
`default_nettype wire

// File: testbench/tecpfd_src_model.sv
// Purpose: External signal source for the counter input pin
// Assumes: Line is always driven, idle low after time zero
// Notes: Edges are launched just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module tecpfd_src_model (
   input wire logic mclk,
   output logic line
);
   initial line = 1'b0;
   // Toggle the line n times, w clock cycles apart
   task automatic edges(input int n, input int w);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk);
         line <= ~line;
         repeat (w - 1) @(posedge mclk);
      end
   endtask
endmodule // tecpfd_src_model
`default_nettype wire

// File: testbench/tecpfd_top_test.sv
// Purpose: Self-checking bench for the timer/event counter
// Assumes: Registers at index*4 byte addresses, AXI4-Lite master here
// Notes: Read results are queued and checked at the read handshake
`timescale 1ns/100ps
`default_nettype none
module tecpfd_top_test;
   import tecpfd_pkg::*;
   typedef struct {tecpfd_rrsp_s r; int tol;} tecpfd_exp_s;
   logic mclk = 0;
   logic arst_n = 0;
   logic [ADDR_W+1:0] awaddr = '0;
   logic [ADDR_W+1:0] araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0;
   logic awready, wready, bvalid, arready, rvalid, irq, wake, pin, oe_n, cin;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] wakes = '0;
   int failures = 0, checked = 0, cyc = 0, t0, v;
   int seed = 32'h0bb89497;
   int psc[3] = '{0, 3, 7};
   tecpfd_exp_s rq[$];
   logic [1:0] bq[$];
   tecpfd_top dut (.mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .count_in(cin), .timer_irq(irq), .wake_up(wake),
      .div_pin_o(pin), .div_pin_oe_n(oe_n));
   tecpfd_src_model src (.mclk(mclk), .line(cin));
   initial forever #10 mclk = ~mclk;
   // ----------------------------------------
   // Compare and bus tasks
   // ----------------------------------------
   task automatic end_sim;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp_sig(input string n, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cmp_rd(input tecpfd_exp_s e, input tecpfd_rrsp_s s);
      logic ok;
      ok = 0;
      for (int k = -e.tol; k <= e.tol; k++) ok = ok | (s.data === 32'(e.r.data + k));
      checked++;
      if (!(ok && s.resp === e.r.resp)) begin
         failures++;
         $display("mismatch read expected %h/%h seen %h/%h", e.r.data, e.r.resp, s.data, s.resp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] e = RESP_OKAY);
      int n;
      n = 0;
      @(posedge mclk);
      bq.push_back(e);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         n++;
      end while (!(bvalid && bready) && n < 100);
      bready <= 0;
      if (n >= 100) failures++;
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] d, input int tol = 0,
                     input logic [1:0] e = RESP_OKAY);
      int n;
      n = 0;
      @(posedge mclk);
      rq.push_back('{{24'h0, d, e}, tol});
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 0;
         n++;
      end while (!(rvalid && rready) && n < 100);
      rready <= 0;
      if (n >= 100) failures++;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (rvalid && rready && rq.size() > 0) cmp_rd(rq.pop_front(), {rdata, rresp});
      if (bvalid && bready && bq.size() > 0) cmp_sig("bresp", 8'(bq.pop_front()), 8'(bresp));
      if (wake === 1'b1) wakes <= wakes + 1;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      end_sim;
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge mclk);
      arst_n <= 1;
      rd(ADDR_CTRL, 8'h08);
      rd(ADDR_COUNT, 8'h00);
      rd(ADDR_INTERRUPT_CONTROL, 8'h00);
      rd(ADDR_PORT, 8'h03);
      rd(10'h3f0, 8'h00, 0, RESP_SLVERR);
      wr(10'h3f0, 8'($random(seed)), RESP_SLVERR);
      wr(ADDR_CTRL, 8'h27);
      rd(ADDR_CTRL, 8'h07);
      wr(ADDR_COUNT, 8'hf0);
      wr(ADDR_CTRL, 8'h10);
      repeat (300) @(posedge mclk);
      rd(ADDR_COUNT, 8'hf0);
      foreach (psc[i]) begin
         wr(ADDR_CTRL, 8'h00);
         wr(ADDR_COUNT, 8'h00);
         t0 = cyc;
         wr(ADDR_CTRL, 8'h90 | 8'(psc[i]));
         while (cyc < t0 + (40 << psc[i])) @(posedge mclk);
         wr(ADDR_CTRL, 8'h80);
         rd(ADDR_COUNT, 8'd40);
      end
      v = 8'h80 | ($random(seed) & 8'h6f);
      wr(ADDR_PORT, 8'h05);
      wr(ADDR_COUNT, 8'(v));
      t0 = cyc;
      wr(ADDR_CTRL, 8'h90);
      wr(ADDR_COUNT, 8'h10);
      rd(ADDR_COUNT, 8'(v + 6));
      while (cyc < t0 + 256 - v + 5) @(posedge mclk);
      wr(ADDR_CTRL, 8'h80);
      rd(ADDR_COUNT, 8'h14);
      cmp_sig("irq", 8'h00, 8'(irq));
      rd(ADDR_INTERRUPT_CONTROL, 8'h20);
      cmp_sig("pin", 8'h01, {6'h0, oe_n, pin});
      wr(ADDR_INTERRUPT_CONTROL, 8'h21);
      repeat (3) @(posedge mclk);
      cmp_sig("irq", 8'h01, 8'(irq));
      wr(ADDR_INTERRUPT_CONTROL, 8'h01);
      wr(ADDR_PORT, 8'h04);
      repeat (3) @(posedge mclk);
      cmp_sig("irq", 8'h00, 8'(irq));
      cmp_sig("pin", 8'h00, {6'h0, oe_n, pin});
      wr(ADDR_PORT, 8'h03);
      repeat (3) @(posedge mclk);
      cmp_sig("oe_n", 8'h01, 8'(oe_n));
      for (int e = 0; e < 2; e++) begin
         wr(ADDR_CTRL, 8'h40 | 8'(e << 3));
         wr(ADDR_COUNT, 8'h00);
         wr(ADDR_CTRL, 8'h50 | 8'(e << 3));
         rd(ADDR_CTRL, 8'h50 | 8'(e << 3));
         src.edges(5, 6);
         repeat (10) @(posedge mclk);
         rd(ADDR_COUNT, 8'(3 - e));
         wr(ADDR_CTRL, 8'h00);
         src.edges(1, 6);
      end
      for (int e = 0; e < 2; e++) begin
         wr(ADDR_CTRL, 8'hc0 | 8'(e << 3));
         wr(ADDR_COUNT, 8'h00);
         wr(ADDR_CTRL, 8'hd0 | 8'(e << 3));
         repeat (20) @(posedge mclk);
         rd(ADDR_COUNT, 8'h00);
         src.edges(1, 10);
         src.edges(2, 30);
         repeat (10) @(posedge mclk);
         rd(ADDR_CTRL, 8'hc0 | 8'(e << 3));
         rd(ADDR_COUNT, 8'd30, 1);
         src.edges(2, 50);
         repeat (10) @(posedge mclk);
         rd(ADDR_COUNT, 8'd30, 1);
      end
      cmp_sig("wakes", 8'h01, wakes);
      end_sim;
   end
endmodule // tecpfd_top_test
`default_nettype wire
